// [rtl/hpsel_params.svh]
// Constants of the host port select block: pin slots, UART timing, indicator sizes.
// Included by the package; holds definitions only.
`ifndef HPSEL_PARAMS_SVH
`define HPSEL_PARAMS_SVH

`define HPSEL_CLK_HZ        32'h017D7840
`define HPSEL_BAUD_RST      32'h00002580
`define HPSEL_DIV_RST       16'(`HPSEL_CLK_HZ / `HPSEL_BAUD_RST)
`define HPSEL_DIV_W         16
`define HPSEL_CNT_W         9
`define HPSEL_NIF           3
`define HPSEL_IF_UART       0
`define HPSEL_IF_DDC        1
`define HPSEL_IF_SPI        2
`define HPSEL_PIN_TX_MISO   0
`define HPSEL_PIN_RX_MOSI   1
`define HPSEL_PIN_SCL_CLK   2
`define HPSEL_PIN_SDA_CS    3
`define HPSEL_LAST_BIT      3'h7
`define HPSEL_BUF_FULL      2'h2

`endif

// [rtl/hpsel_pkg.sv]
// Types shared by the host port select top and its UART.
// Assumes hpsel_params.svh sits beside it on the include path.
package hpsel_pkg;
`include "hpsel_params.svh"

    typedef enum logic [1:0] {
        HPSEL_MODE_UD  = 2'h1,
        HPSEL_MODE_SPI = 2'h2
    } hpsel_mode_t;

    typedef enum logic [3:0] {
        HPSEL_IDLE  = 4'h1,
        HPSEL_START = 4'h2,
        HPSEL_DATA  = 4'h4,
        HPSEL_STOP  = 4'h8
    } hpsel_uart_st_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } hpsel_byte_t;

    typedef struct packed {
        logic                    en;
        logic                    pol;
        logic [`HPSEL_CNT_W-1:0] thresh;
    } hpsel_txr_cfg_t;

    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } hpsel_pins_t;

    typedef struct packed {
        hpsel_uart_st_t          tx_st;
        logic [`HPSEL_DIV_W-1:0] tx_cnt;
        logic [2:0]              tx_bit;
        logic [7:0]              tx_sh;
        logic                    tx_pin;
        hpsel_uart_st_t          rx_st;
        logic [`HPSEL_DIV_W-1:0] rx_cnt;
        logic [2:0]              rx_bit;
        logic [7:0]              rx_sh;
        hpsel_byte_t             rx_out;
    } hpsel_uart_state_t;

    typedef struct packed {
        logic                      done;
        hpsel_mode_t               mode;
        hpsel_pins_t               pins;
        logic                      ddc_scl;
        logic                      ddc_sda;
        logic                      spi_mosi;
        logic                      spi_clk;
        logic                      spi_cs_n;
        logic [`HPSEL_DIV_W-1:0]   div;
        logic [1:0][7:0]           buf_data;
        logic [1:0]                buf_cnt;
        logic                      buf_wr;
        logic                      buf_rd;
        logic [`HPSEL_NIF-1:0]     txr;
        logic                      wake;
        logic                      rx_prev;
    } hpsel_top_state_t;
endpackage

// [rtl/hpsel_top.sv]
// Host port select: strap-chosen pin mapping of UART plus DDC or SPI onto four shared
// pins, a two-entry UART transmit buffer, data-pending indicators and wake on RX.
// Assumes DDC and SPI protocol cores sit outside; pins are open-drain where DDC.
`timescale 1ns/1ns
`default_nettype none
module hpsel_top
    import hpsel_pkg::*;
(
    input  wire logic                                  i_sys_clk,    // 25 MHz clock
    input  wire logic                                  i_rst_n,      // Async reset, active low
    input  wire logic                                  i_sel_strap,  // 1 or open: UART+DDC
    input  wire logic [3:0]                            i_pin,        // Shared pin levels
    output hpsel_pkg::hpsel_pins_t                     o_pins,       // Shared pin drive
    input  wire hpsel_pkg::hpsel_byte_t                i_tx,         // UART byte to send
    output logic                                       o_tx_ready,   // Buffer has room
    output hpsel_pkg::hpsel_byte_t                     o_rx,         // UART byte received
    input  wire logic                                  i_baud_wr,    // Load new divisor
    input  wire logic [`HPSEL_DIV_W-1:0]               i_baud_div,   // Clocks per bit
    input  wire logic                                  i_ddc_scl_low,// DDC core holds SCL
    input  wire logic                                  i_ddc_sda_low,// DDC core pulls SDA
    output logic                                       o_ddc_scl,    // SCL to DDC core
    output logic                                       o_ddc_sda,    // SDA to DDC core
    input  wire logic                                  i_spi_miso,   // SPI core data out
    output logic                                       o_spi_mosi,   // SPI data to core
    output logic                                       o_spi_clk,    // SPI clock to core
    output logic                                       o_spi_cs_n,   // SPI select, active low
    output logic                                       o_spi_mode,   // SPI mapping chosen
    input  wire hpsel_pkg::hpsel_txr_cfg_t [`HPSEL_NIF-1:0] i_txr_cfg,// Indicator config
    input  wire logic [`HPSEL_NIF-1:0][`HPSEL_CNT_W-1:0]    i_pend_cnt,// Bytes pending
    output logic [`HPSEL_NIF-1:0]                      o_txr,        // Indicator pins
    input  wire logic                                  i_psm,        // Power save active
    output logic                                       o_wake        // Wake request pulse
);
    import hpsel_pkg::*;

    hpsel_top_state_t st_ff;
    hpsel_top_state_t nxt_st;
    logic             uart_en;
    logic             ud_on;
    logic             spi_on;
    logic             uart_ready;
    logic             uart_tx_pin;
    logic             rx_level;
    logic             push;
    logic             pop;
    hpsel_byte_t      buf_out;
    logic [`HPSEL_NIF-1:0] txr_lvl;

    assign ud_on = st_ff.done && st_ff.mode == HPSEL_MODE_UD;
    assign spi_on = st_ff.done && st_ff.mode == HPSEL_MODE_SPI;
    assign uart_en = ud_on;
    // Unmapped RX reads idle so the UART never sees SPI traffic
    assign rx_level = ud_on ? i_pin[`HPSEL_PIN_RX_MOSI] : 1'b1;
    assign o_tx_ready = st_ff.buf_cnt != `HPSEL_BUF_FULL;
    assign push = i_tx.valid && o_tx_ready;
    assign buf_out.valid = st_ff.buf_cnt != 2'h0;
    assign buf_out.data = st_ff.buf_data[st_ff.buf_rd];
    assign pop = buf_out.valid && uart_ready;

    // Level is active while enabled, its interface mapped and count at or above threshold
    for (genvar g = 0; g < `HPSEL_NIF; g++)
    begin : g_txr
        logic live;
        assign live = (g == `HPSEL_IF_SPI) ? spi_on : ud_on;
        assign txr_lvl[g] = (i_txr_cfg[g].en && live
                             && i_pend_cnt[g] >= i_txr_cfg[g].thresh)
                            ? i_txr_cfg[g].pol : !i_txr_cfg[g].pol;
    end

    hpsel_uart u_uart (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_en       (uart_en),
        .i_div      (st_ff.div),
        .i_tx       (buf_out),
        .o_tx_ready (uart_ready),
        .o_tx_pin   (uart_tx_pin),
        .i_rx_pin   (rx_level),
        .o_rx       (o_rx)
    );

    always_comb
    begin
        nxt_st = st_ff;
        if (!st_ff.done)
        begin
            nxt_st.done = 1'b1;
            nxt_st.mode = i_sel_strap ? HPSEL_MODE_UD : HPSEL_MODE_SPI;
        end
        if (i_baud_wr)
            nxt_st.div = i_baud_div;
        if (push)
        begin
            nxt_st.buf_data[st_ff.buf_wr] = i_tx.data;
            nxt_st.buf_wr = !st_ff.buf_wr;
        end
        if (pop)
            nxt_st.buf_rd = !st_ff.buf_rd;
        nxt_st.buf_cnt = st_ff.buf_cnt + {1'b0, push} - {1'b0, pop};
        nxt_st.pins = '0;
        nxt_st.ddc_scl = 1'b1;
        nxt_st.ddc_sda = 1'b1;
        nxt_st.spi_mosi = 1'b0;
        nxt_st.spi_clk = 1'b0;
        nxt_st.spi_cs_n = 1'b1;
        if (ud_on)
        begin
            nxt_st.pins.o[`HPSEL_PIN_TX_MISO] = uart_tx_pin;
            nxt_st.pins.oe[`HPSEL_PIN_TX_MISO] = 1'b1;
            nxt_st.pins.oe[`HPSEL_PIN_SCL_CLK] = i_ddc_scl_low;
            nxt_st.pins.oe[`HPSEL_PIN_SDA_CS] = i_ddc_sda_low;
            nxt_st.ddc_scl = i_pin[`HPSEL_PIN_SCL_CLK];
            nxt_st.ddc_sda = i_pin[`HPSEL_PIN_SDA_CS];
        end
        else if (spi_on)
        begin
            // MISO floats while deselected so a shared bus stays free
            nxt_st.pins.o[`HPSEL_PIN_TX_MISO] = i_spi_miso;
            nxt_st.pins.oe[`HPSEL_PIN_TX_MISO] = !i_pin[`HPSEL_PIN_SDA_CS];
            nxt_st.spi_mosi = i_pin[`HPSEL_PIN_RX_MOSI];
            nxt_st.spi_clk = i_pin[`HPSEL_PIN_SCL_CLK];
            nxt_st.spi_cs_n = i_pin[`HPSEL_PIN_SDA_CS];
        end
        nxt_st.txr = txr_lvl;
        nxt_st.rx_prev = rx_level;
        nxt_st.wake = i_psm && ud_on && (rx_level != st_ff.rx_prev);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_ff <= '0;
            st_ff.mode <= HPSEL_MODE_UD;
            st_ff.ddc_scl <= 1'b1;
            st_ff.ddc_sda <= 1'b1;
            st_ff.spi_cs_n <= 1'b1;
            st_ff.div <= `HPSEL_DIV_RST;
            st_ff.rx_prev <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign o_pins = st_ff.pins;
    assign o_ddc_scl = st_ff.ddc_scl;
    assign o_ddc_sda = st_ff.ddc_sda;
    assign o_spi_mosi = st_ff.spi_mosi;
    assign o_spi_clk = st_ff.spi_clk;
    assign o_spi_cs_n = st_ff.spi_cs_n;
    assign o_spi_mode = spi_on;
    // Reset value is inactive for pol=1, since config arrives after reset
    assign o_txr = st_ff.txr;
    assign o_wake = st_ff.wake;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_mapped;
        st_ff.done;
    endsequence
    chk_strap_held: assert property (s_mapped |=> $stable(st_ff.mode) && st_ff.done)
        else $error("Pin mapping changed without reset");
    chk_strap_taken: assert property (!st_ff.done |=> st_ff.done
                                      && (spi_on == !$past(i_sel_strap)))
        else $error("Strap not applied one cycle after reset");
    chk_spi_excl: assert property (spi_on |=> !o_pins.oe[`HPSEL_PIN_SCL_CLK]
                                   && !o_pins.oe[`HPSEL_PIN_SDA_CS]
                                   && o_ddc_scl && o_ddc_sda)
        else $error("DDC active while SPI mapped");
    chk_uart_map: assert property (ud_on |=> o_pins.oe[`HPSEL_PIN_TX_MISO]
                                   && o_pins.o[`HPSEL_PIN_TX_MISO] == $past(uart_tx_pin))
        else $error("UART TX not on shared pin");
    chk_txr_off: assert property (!i_txr_cfg[`HPSEL_IF_DDC].en
                                  |=> o_txr[`HPSEL_IF_DDC] == !$past(i_txr_cfg[`HPSEL_IF_DDC].pol))
        else $error("Disabled indicator not inactive");
    chk_txr_level: assert property (ud_on && i_txr_cfg[`HPSEL_IF_DDC].en
                                    |=> o_txr[`HPSEL_IF_DDC] == (($past(i_pend_cnt[`HPSEL_IF_DDC])
                                        >= $past(i_txr_cfg[`HPSEL_IF_DDC].thresh))
                                        == $past(i_txr_cfg[`HPSEL_IF_DDC].pol)))
        else $error("Indicator level wrong for count and polarity");
    chk_baud_load: assert property (i_baud_wr |=> st_ff.div == $past(i_baud_div))
        else $error("Bit rate divisor not loaded");
    // Second cycle may pulse again only for a fresh change one cycle later
    chk_wake_edge: assert property (i_psm && ud_on && $changed(rx_level) |=> o_wake
                                    ##1 (!o_wake
                                         || $past(rx_level) != $past(rx_level, 2)))
        else $error("RX change in power save did not wake");
    chk_buf_bound: assert property (st_ff.buf_cnt == `HPSEL_BUF_FULL |-> !o_tx_ready
                                    ##1 st_ff.buf_cnt != 2'h3)
        else $error("Transmit buffer overflowed");
endmodule
`default_nettype wire

// [rtl/hpsel_uart.sv]
// Asynchronous 8N1 UART, transmit and receive, bit time set by a clock divisor.
// Assumes i_rx_pin is synchronous to i_sys_clk and idles high when unused.
`timescale 1ns/1ns
`default_nettype none
module hpsel_uart
    import hpsel_pkg::*;
(
    input  wire logic                    i_sys_clk,   // System clock
    input  wire logic                    i_rst_n,     // Async reset, active low
    input  wire logic                    i_en,        // UART owns the pins
    input  wire logic [`HPSEL_DIV_W-1:0] i_div,       // Clocks per bit
    input  wire hpsel_pkg::hpsel_byte_t  i_tx,        // Byte to send
    output logic                         o_tx_ready,  // Enabled and idle: a valid byte is taken this cycle
    output logic                         o_tx_pin,    // Serial out, idle high
    input  wire logic                    i_rx_pin,    // Serial in
    output hpsel_pkg::hpsel_byte_t       o_rx         // Received byte, one-cycle valid
);
    import hpsel_pkg::*;

    hpsel_uart_state_t st_ff;
    hpsel_uart_state_t nxt_st;
    logic [`HPSEL_DIV_W-1:0] bit_last;

    assign bit_last = i_div - `HPSEL_DIV_W'(1);
    // No handshake lines: sending depends only on i_en, the transmitter being idle and i_tx.valid
    assign o_tx_ready = i_en && (st_ff.tx_st == HPSEL_IDLE);
    assign o_tx_pin = st_ff.tx_pin;
    assign o_rx = st_ff.rx_out;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rx_out.valid = 1'b0;
        if (st_ff.tx_cnt != '0)
            nxt_st.tx_cnt = st_ff.tx_cnt - `HPSEL_DIV_W'(1);
        if (st_ff.rx_cnt != '0)
            nxt_st.rx_cnt = st_ff.rx_cnt - `HPSEL_DIV_W'(1);
        case (st_ff.tx_st)
            HPSEL_IDLE:
                if (o_tx_ready && i_tx.valid)
                begin
                    nxt_st.tx_sh = i_tx.data;
                    nxt_st.tx_pin = 1'b0;
                    nxt_st.tx_cnt = bit_last;
                    nxt_st.tx_st = HPSEL_START;
                end
            HPSEL_START, HPSEL_DATA:
                if (st_ff.tx_cnt == '0)
                begin
                    nxt_st.tx_cnt = bit_last;
                    if (st_ff.tx_st == HPSEL_DATA && st_ff.tx_bit == `HPSEL_LAST_BIT)
                    begin
                        nxt_st.tx_pin = 1'b1;
                        nxt_st.tx_st = HPSEL_STOP;
                    end
                    else
                    begin
                        nxt_st.tx_pin = st_ff.tx_sh[0];
                        nxt_st.tx_sh = {1'b0, st_ff.tx_sh[7:1]};
                        nxt_st.tx_bit = (st_ff.tx_st == HPSEL_START) ? 3'h0
                                        : st_ff.tx_bit + 3'h1;
                        nxt_st.tx_st = HPSEL_DATA;
                    end
                end
            HPSEL_STOP:
                if (st_ff.tx_cnt == '0)
                    nxt_st.tx_st = HPSEL_IDLE;
            default:
                nxt_st.tx_st = HPSEL_IDLE;
        endcase
        case (st_ff.rx_st)
            HPSEL_IDLE:
                if (i_en && !i_rx_pin)
                begin
                    // Check the start bit at its middle to reject glitches
                    nxt_st.rx_cnt = {1'b0, i_div[`HPSEL_DIV_W-1:1]};
                    nxt_st.rx_st = HPSEL_START;
                end
            HPSEL_START:
                if (st_ff.rx_cnt == '0)
                begin
                    nxt_st.rx_cnt = bit_last;
                    nxt_st.rx_bit = 3'h0;
                    nxt_st.rx_st = i_rx_pin ? HPSEL_IDLE : HPSEL_DATA;
                end
            HPSEL_DATA:
                if (st_ff.rx_cnt == '0)
                begin
                    nxt_st.rx_sh = {i_rx_pin, st_ff.rx_sh[7:1]};
                    nxt_st.rx_cnt = bit_last;
                    nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
                    if (st_ff.rx_bit == `HPSEL_LAST_BIT)
                        nxt_st.rx_st = HPSEL_STOP;
                end
            HPSEL_STOP:
                if (st_ff.rx_cnt == '0)
                begin
                    // Framing error drops the byte silently
                    nxt_st.rx_out.valid = i_rx_pin;
                    nxt_st.rx_out.data = st_ff.rx_sh;
                    nxt_st.rx_st = HPSEL_IDLE;
                end
            default:
                nxt_st.rx_st = HPSEL_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_ff <= '0;
            st_ff.tx_st <= HPSEL_IDLE;
            st_ff.rx_st <= HPSEL_IDLE;
            st_ff.tx_pin <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_tx_take;
        o_tx_ready && i_tx.valid;
    endsequence
    chk_tx_start_bit: assert property (s_tx_take |=> !o_tx_pin && !o_tx_ready)
        else $error("UART start bit missing after byte taken");
    chk_tx_idle_high: assert property (st_ff.tx_st == HPSEL_IDLE |-> o_tx_pin)
        else $error("UART line not high while idle");
    chk_rx_one_pulse: assert property (o_rx.valid |=> !o_rx.valid)
        else $error("Receive valid held longer than one cycle");
endmodule
`default_nettype wire

// [verification/hpsel_host_model.sv]
// Host UART partner: decodes the device serial output and sends bytes to its input.
// Assumes the bench supplies the bit time in clocks; both lines idle high.
`timescale 1ns/1ns
`default_nettype none
module hpsel_host_model (
    input  wire logic                    i_sys_clk, // Clock
    input  wire logic                    i_rst_n,   // Reset, active low
    input  wire logic [`HPSEL_DIV_W-1:0] i_div,     // Clocks per bit
    input  wire logic                    i_line,    // Device serial out
    input  wire hpsel_pkg::hpsel_byte_t  i_send,    // Byte to send
    output logic                         o_busy,    // Frame going out
    output logic                         o_line,    // Serial to device
    output hpsel_pkg::hpsel_byte_t       o_got      // Decoded byte, one cycle
);
    import hpsel_pkg::*;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    // Samples on the falling edge, clear of the device's register updates
    initial
    begin
        o_got = '0;
        forever
        begin
            @(negedge i_sys_clk);
            o_got.valid <= 1'b0;
            if (i_rst_n && !i_line)
            begin
                repeat (i_div / 2) @(negedge i_sys_clk);
                // Start rechecked mid-bit: a short low from a select change is no frame
                if (!i_line)
                begin
                    for (int i = 0; i < 8; i++)
                    begin
                        repeat (i_div) @(negedge i_sys_clk);
                        rx_sh[i] = i_line;
                    end
                    repeat (i_div) @(negedge i_sys_clk);
                    if (i_line)
                        o_got <= '{valid: 1'b1, data: rx_sh};
                end
            end
        end
    end
    // 8N1 only, no handshake lines
    initial
    begin
        o_line = 1'b1;
        o_busy = 1'b0;
        forever
        begin
            @(posedge i_sys_clk);
            if (i_send.valid && !o_busy)
            begin
                tx_sh = i_send.data;
                o_busy <= 1'b1;
                for (int i = 0; i < 10; i++)
                begin
                    o_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : tx_sh[i-1];
                    repeat (i_div) @(posedge i_sys_clk);
                end
                o_busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/tb_host_port_select_uart_txready.sv]
// Bench of the host port select block: mapping, indicators, UART, buffer, wake.
// Assumes the rtl package and hpsel_host_model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb_host_port_select_uart_txready;
    import hpsel_pkg::*;
    logic                 clk, rst_n, strap, baud_wr, scl_lo, sda_lo, miso, psm, p2, p3;
    logic                 full, rdy, scl, sda, mosi, sck, cs_n, spi, wake, busy, hline;
    logic [3:0]           pin;
    logic [15:0]          div, hdiv, seed, b;
    logic [2:0]           txr;
    logic [2:0][8:0]      pend;
    hpsel_pins_t          pins;
    hpsel_byte_t          tx, rx, send, got;
    hpsel_txr_cfg_t [2:0] cfg;
    logic [7:0]           exp_tx[$];
    logic [7:0]           exp_rx[$];
    int                   error_cnt, compares, wake_cnt, n;
    // Pull-ups on shared pins 0, 2 and 3, pin 1 driven by the host; open-drain pulls win
    assign pin = {(pins.oe[3] && !pins.o[3]) ? 1'b0 : p3, (pins.oe[2] && !pins.o[2]) ? 1'b0 : p2,
                  hline, pins.oe[0] ? pins.o[0] : 1'b1};
    hpsel_top DUT (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_sel_strap(strap), .i_pin(pin), .o_pins(pins),
        .i_tx(tx), .o_tx_ready(rdy), .o_rx(rx), .i_baud_wr(baud_wr), .i_baud_div(div),
        .i_ddc_scl_low(scl_lo), .i_ddc_sda_low(sda_lo), .o_ddc_scl(scl), .o_ddc_sda(sda),
        .i_spi_miso(miso), .o_spi_mosi(mosi), .o_spi_clk(sck), .o_spi_cs_n(cs_n),
        .o_spi_mode(spi), .i_txr_cfg(cfg), .i_pend_cnt(pend), .o_txr(txr), .i_psm(psm),
        .o_wake(wake));
    hpsel_host_model host (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_div(hdiv), .i_line(pin[0]), .i_send(send),
        .o_busy(busy), .o_line(hline), .o_got(got));
    task automatic stop_test();
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic take(input string name, ref logic [7:0] q[$], input logic [7:0] g);
        compares++;
        if (q.size() == 0 || q[0] !== g)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, (q.size() == 0) ? 8'h00 : q[0], g);
        end
        if (q.size() != 0)
            q.pop_front();
    endtask
    task automatic tmo(input int k, input int lim);
        if (k >= lim)
        begin
            error_cnt++;
            $display("ERROR wait expected done seen timeout");
            stop_test();
        end
    endtask
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction
    task automatic put_byte(input logic [7:0] v);
        tx = '{valid: 1'b1, data: v};
        exp_tx.push_back(v);
        for (n = 0; n < 40000 && !rdy; n++)
        begin
            full = 1'b1;
            @(negedge clk);
        end
        tmo(n, 40000);
        @(negedge clk);
    endtask
    task automatic host_send(input logic [7:0] v, input logic want);
        send = '{valid: 1'b1, data: v};
        if (want)
            exp_rx.push_back(v);
        for (n = 0; n < 10 && !busy; n++)
            @(negedge clk);
        tmo(n, 10);
        send.valid = 1'b0;
        for (n = 0; n < 40000 && busy; n++)
            @(negedge clk);
        tmo(n, 40000);
        repeat (4) @(negedge clk);
    endtask
    task automatic drain();
        for (n = 0; n < 40000 && exp_tx.size() + exp_rx.size() != 0; n++)
            @(negedge clk);
        tmo(n, 40000);
    endtask
    task automatic ind(input int i, input logic [8:0] c, input logic e);
        pend[i] = c;
        @(negedge clk);
        chk("txr", {15'h0000, e}, {15'h0000, txr[i]});
    endtask
    always @(negedge clk)
    begin
        if (got.valid)
            take("host_rx", exp_tx, got.data);
        if (rx.valid)
            take("dut_rx", exp_rx, rx.data);
        if (wake)
            wake_cnt++;
    end
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        {error_cnt, compares, wake_cnt} = '0;
        {rst_n, baud_wr, scl_lo, sda_lo, miso, psm, full} = '0;
        {strap, p2, p3} = 3'h7;
        {tx, send, cfg, pend} = '0;
        seed = 16'h399B;
        div = 16'h0000;
        hdiv = 16'h0A2C;
        repeat (4) @(negedge clk);
        chk("txr_rst", 16'h0000, {13'h0000, txr});
        chk("tx_ready", 16'h0001, {15'h0000, rdy});
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("spi_mode", 16'h0000, {15'h0000, spi});
        cfg = {3{1'b0, 1'b1, 9'h005}};
        pend = {3{9'h005}};
        @(negedge clk);
        chk("txr_off", 16'h0000, {13'h0000, txr});
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 3; i++)
            begin
                cfg[i] = '{en: 1'b1, pol: p[0], thresh: 9'h005};
                ind(i, 9'h004, !p[0]);
                ind(i, 9'h005, (i < 2) ? p[0] : !p[0]);
                ind(i, 9'h004, !p[0]);
                cfg[i].en = 1'b0;
            end
        put_byte(8'h01);
        tx.valid = 1'b0;
        for (n = 0; n < 8 && pins.o[0]; n++)
            @(negedge clk);
        tmo(n, 8);
        for (n = 0; n < 3000 && !pins.o[0]; n++)
            @(negedge clk);
        chk("start_bit", 16'h0A2C, n[15:0]);
        drain();
        repeat (1400) @(negedge clk);
        {baud_wr, div, hdiv} = {1'b1, 16'h0010, 16'h0010};
        @(negedge clk);
        baud_wr = 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            b = xs();
            put_byte(b[7:0]);
        end
        tx.valid = 1'b0;
        chk("buf_full", 16'h0001, {15'h0000, full});
        drain();
        for (int k = 0; k < 3; k++)
        begin
            b = xs();
            host_send(b[7:0], 1'b1);
        end
        {psm, wake_cnt} = {1'b1, 32'h0};
        host_send(8'h55, 1'b1);
        chk("wake_cnt", 16'h000A, wake_cnt[15:0]);
        {psm, wake_cnt} = {1'b0, 32'h0};
        host_send(8'hA5, 1'b1);
        chk("wake_off", 16'h0000, wake_cnt[15:0]);
        {scl_lo, sda_lo, p3} = 3'h5;
        @(negedge clk);
        chk("ddc_oe", 16'h0100, {6'h00, pins.oe[3:2], 6'h00, pins.o[3:2]});
        @(negedge clk);
        chk("ddc_in", 16'h0001, {14'h0000, scl, sda});
        chk("spi_off", 16'h0001, {13'h0000, mosi, sck, cs_n});
        strap = 1'b0;
        repeat (3) @(negedge clk);
        chk("strap_held", 16'h0000, {15'h0000, spi});
        {rst_n, scl_lo, sda_lo, p3, miso} = 5'h03;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("spi_mode", 16'h0001, {15'h0000, spi});
        strap = 1'b1;
        repeat (3) @(negedge clk);
        chk("spi_held", 16'h0103, {7'h00, spi, 6'h00, scl, sda});
        {p3, p2} = 2'h0;
        @(negedge clk);
        chk("spi_pins", 16'h1120,
            {3'h0, pins.oe[0], 3'h0, pins.o[0], 2'h0, mosi, cs_n, 3'h0, sck});
        miso = 1'b0;
        @(negedge clk);
        chk("miso", 16'h0000, {15'h0000, pins.o[0]});
        {p3, p2, miso} = 3'h7;
        put_byte(8'h3C);
        tx.valid = 1'b0;
        exp_tx.delete();
        {psm, wake_cnt} = {1'b1, 32'h0};
        host_send(8'h55, 1'b0);
        chk("spi_wake", 16'h0000, wake_cnt[15:0]);
        cfg = {1'b1, 1'b1, 9'h005, 1'b0, 1'b1, 9'h005, 1'b1, 1'b1, 9'h005};
        ind(2, 9'h005, 1'b1);
        // Host selects the device only once the indicator is up
        for (n = 0; n < 8 && !txr[2]; n++)
            @(negedge clk);
        tmo(n, 8);
        p3 = 1'b0;
        @(negedge clk);
        chk("spi_read", 16'h0010, {11'h000, pins.oe[0], 3'h0, cs_n});
        ind(0, 9'h005, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
